//--- shared/sscm_pkg.sv
// sscm_pkg: constants and types for the stop and subclock mode controller
// assumes a 32-bit apb slave with word-aligned registers
package sscm_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PROC_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAB_TIME     = 8'h04;
    localparam logic [7:0] OFF_STOP_CTRL     = 8'h08;
    localparam logic [7:0] OFF_PERIPH_CFG    = 8'h0c;
    localparam logic [7:0] OFF_STATUS        = 8'h10;
    localparam logic [7:0] OFF_DAC_CTRL      = 8'h14;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PCC_DIV_LSB   = 0;
    localparam int PCC_SUBSEL    = 3;
    localparam int PCC_CLS       = 4;
    localparam int PCC_MOSC_STOP = 6;
    localparam int PCFG_WDT_IOSC = 0;
    localparam int PCFG_WDT_SUB  = 1;
    localparam int PCFG_CSI_LSB  = 2;
    localparam int PCFG_UART0EXT = 7;
    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [2:0] DIV_RST         = 3'h3;
    localparam logic [2:0] STAB_SEL_RST    = 3'h4;
    localparam int         STAB_EXP_BASE   = 12;
    localparam int         STAB_EXP_MAX    = 16;
    localparam int         CLS_SYNC_CYC    = 4;
    localparam int         DAC_SETTLE_CYC  = 8;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_STOP   = 2'b01,
        ST_STABLE = 2'b10
    } sscm_state_t;

    typedef struct packed {
        logic       wdt2_run;
        logic [4:0] csi_run;
        logic       i2c_run;
        logic [2:0] uart_run;
        logic       adc_halt;
        logic       adc_invalid;
        logic       dac_hiz;
        logic       rto_hold;
        logic       port_hold;
        logic       cpu_hold;
    } sscm_periph_t;
endpackage

//--- verilog/sscm_stab_timer.sv
// sscm_stab_timer: oscillation stabilisation counter
// assumes load and enable are synchronous to clk
`timescale 1ns/100ps
module sscm_stab_timer #(
    parameter int WIDTH = 17
) (
    input  wire logic             clk,     // system clock
    input  wire logic             rst_n,   // async reset, active low
    input  wire logic             ce,      // clock enable
    input  wire logic             load,    // start a new wait
    input  wire logic [WIDTH-1:0] length,  // wait length in cycles
    output logic                  ovf      // one-cycle overflow pulse
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic             run_r;
    logic             run_nxt;
    logic             ovf_r;
    logic             ovf_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        ovf_nxt = 1'b0;
        if (load) begin
            cnt_nxt = length;
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (cnt_r <= WIDTH'(1)) begin
                run_nxt = 1'b0;
                ovf_nxt = 1'b1;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            ovf_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    assign ovf = ovf_r;
endmodule

//--- verilog/sscm_top.sv
// sscm_top: stop mode and subclock mode controller with apb registers
// assumes apb master on CLK; wake sources and peripheral clock selects synchronous
`timescale 1ns/100ps
// Summary of operation
// - leave stop on nmi, unmasked interrupt from running unit, or reset
// - watchdog 2 counts in stop only on internal osc, or subclock when used
// - clocked serial units run in stop only with external serial clock
// - two-wire and async serial units halt, unit zero runs on external baud
// - converter halts in stop, restarts after; results around stop flagged invalid
// - dac running at stop entry halts and floats its pin
// - dac resumes after stop, restores prior level after settling time
// - realtime output unit halts in stop, output pins frozen
// - ports keep configuration and pin state through stop
// - cpu registers, flags and ram are preserved during stop
// - interrupt release loads stabilisation counter, resume on overflow
// - reset restores stabilisation select to 2^16 main periods; reset release itself has no wait
// - writing subclock select in normal mode switches system clock to subclock
// - read-only clock source status shows switch to subclock done
// - writing main osc stop halts main oscillator, whether or not subclock is selected
module sscm_top #(
    parameter int STAB_W = 17
) (
    input  wire logic                  CLK,          // system clock
    input  wire logic                  RST_N,        // async reset, active low
    input  wire logic                  CE,           // clock enable
    input  wire logic                  PSEL,         // apb select
    input  wire logic                  PENABLE,      // apb enable
    input  wire logic                  PWRITE,       // apb write
    input  wire logic [7:0]            PADDR,        // apb address
    input  wire logic [31:0]           PWDATA,       // apb write data
    output logic      [31:0]           PRDATA,       // apb read data
    output logic                       PREADY,       // apb ready
    output logic                       PSLVERR,      // apb error
    input  wire logic                  NMI_REQ,      // non-maskable wake
    input  wire logic                  INT_REQ,      // unmasked interrupt from running unit
    input  wire logic                  SUB_USED,     // subclock oscillator in use
    input  wire logic                  WDT2_IOSC,    // watchdog 2 on internal osc
    input  wire logic                  WDT2_SUB,     // watchdog 2 on subclock
    input  wire logic [4:0]            CSI_EXTCLK,   // clocked serial unit on ext clock
    input  wire logic                  UART0_EXTCLK, // async unit zero on ext baud clock
    input  wire logic                  ADC_BUSY,     // converter busy
    input  wire logic                  DAC_ACTIVE,   // dac converting
    input  wire logic                  SUB_READY,    // subclock switch acknowledged
    output sscm_pkg::sscm_periph_t     PERIPH,       // peripheral run and hold controls
    output logic                       MAIN_OSC_EN,  // main oscillator enable
    output logic                       SYSCLK_SUB,   // system clock from subclock
    output logic      [2:0]            SYS_DIV,      // system clock divider
    output logic                       DAC_OE_N,     // dac pin enable, low drives
    output logic                       DAC_RESTORE,  // dac settled, prior level back
    output logic                       IN_STOP       // stop mode active
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [2:0]            div_r,      div_nxt;
    logic                  subsel_r,   subsel_nxt;
    logic                  moscstp_r,  moscstp_nxt;
    logic [2:0]            stab_r,     stab_nxt;
    logic                  adc_inv_r,  adc_inv_nxt;
    logic                  dac_hold_r, dac_hold_nxt;
    logic [3:0]            settle_r,   settle_nxt;
    logic                  cls_r,      cls_nxt;
    logic [2:0]            cls_cnt_r,  cls_cnt_nxt;
    logic [31:0]           rdata_r,    rdata_nxt;
    logic                  err_r,      err_nxt;
    logic                  ready_r,    ready_nxt;
    sscm_pkg::sscm_state_t state_r,    state_nxt;
    logic                  stab_load;
    logic                  stab_ovf;
    logic [STAB_W-1:0]     stab_len;
    logic                  wr_en;
    logic                  rd_en;
    logic                  stop_req;
    logic                  wake;

    // writes commit at the edge that completes the transfer, with pready high
    assign wr_en    = PSEL && PENABLE && PWRITE && ready_r;
    assign rd_en    = PSEL && PENABLE && !PWRITE && !ready_r;
    assign stop_req = wr_en && (PADDR == sscm_pkg::OFF_STOP_CTRL) && PWDATA[0];
    assign wake     = NMI_REQ || INT_REQ;

    // ------------------------------------------------------------------
    // stabilisation length: 2^(base+sel), capped at 2^16
    // ------------------------------------------------------------------
    always_comb begin
        int e;
        e = sscm_pkg::STAB_EXP_BASE + int'(stab_r);
        if (e > sscm_pkg::STAB_EXP_MAX) begin
            e = sscm_pkg::STAB_EXP_MAX;
        end
        stab_len = STAB_W'(1) << e;
    end

    sscm_stab_timer #(
        .WIDTH (STAB_W)
    ) u_stab (
        .clk    (CLK),
        .rst_n  (RST_N),
        .ce     (CE),
        .load   (stab_load),
        .length (stab_len),
        .ovf    (stab_ovf)
    );

    // ------------------------------------------------------------------
    // stop sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        stab_load    = 1'b0;
        adc_inv_nxt  = adc_inv_r;
        dac_hold_nxt = dac_hold_r;
        settle_nxt   = settle_r;
        case (state_r)
            sscm_pkg::ST_RUN: begin
                if (settle_r != 4'h0) begin
                    settle_nxt = settle_r - 4'h1;
                end
                if (stop_req && !wake) begin
                    // pending wake cancels entry at once
                    state_nxt = sscm_pkg::ST_STOP;
                    if (ADC_BUSY) begin
                        adc_inv_nxt = 1'b1;
                    end
                    dac_hold_nxt = DAC_ACTIVE;
                end else if (wr_en && PADDR == sscm_pkg::OFF_STATUS && PWDATA[1]) begin
                    adc_inv_nxt = 1'b0;
                end
            end
            sscm_pkg::ST_STOP: begin
                if (wake) begin
                    state_nxt = sscm_pkg::ST_STABLE;
                    stab_load = 1'b1;
                end
            end
            sscm_pkg::ST_STABLE: begin
                if (stab_ovf) begin
                    state_nxt = sscm_pkg::ST_RUN;
                    if (dac_hold_r) begin
                        settle_nxt = 4'(sscm_pkg::DAC_SETTLE_CYC);
                    end
                    dac_hold_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = sscm_pkg::ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // clock control and status
    // ------------------------------------------------------------------
    always_comb begin
        div_nxt     = div_r;
        subsel_nxt  = subsel_r;
        moscstp_nxt = moscstp_r;
        stab_nxt    = stab_r;
        cls_nxt     = cls_r;
        cls_cnt_nxt = cls_cnt_r;
        if (wr_en && PADDR == sscm_pkg::OFF_PROC_CLK_CTRL) begin
            // software is trusted to keep the divider and its ratio
            div_nxt = PWDATA[sscm_pkg::PCC_DIV_LSB +: 3];
            if (PWDATA[sscm_pkg::PCC_SUBSEL] && state_r == sscm_pkg::ST_RUN) begin
                subsel_nxt = 1'b1;
            end
            moscstp_nxt = PWDATA[sscm_pkg::PCC_MOSC_STOP];
        end
        if (wr_en && PADDR == sscm_pkg::OFF_STAB_TIME) begin
            stab_nxt = PWDATA[2:0];
        end
        // switch completes only after a fixed delay and the clock mux ack
        if (subsel_r && !cls_r) begin
            if (cls_cnt_r != 3'(sscm_pkg::CLS_SYNC_CYC)) begin
                cls_cnt_nxt = cls_cnt_r + 3'h1;
            end else if (SUB_READY) begin
                cls_nxt = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // apb read and answer
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt   = 1'b0;
        ready_nxt = PSEL && PENABLE && !ready_r;
        if (rd_en) begin
            if (PADDR == sscm_pkg::OFF_PROC_CLK_CTRL) begin
                rdata_nxt = {25'h0, moscstp_r, 1'b0, cls_r, subsel_r, div_r};
            end else if (PADDR == sscm_pkg::OFF_STAB_TIME) begin
                rdata_nxt = {29'h0, stab_r};
            end else if (PADDR == sscm_pkg::OFF_STOP_CTRL) begin
                rdata_nxt = {31'h0, IN_STOP};
            end else if (PADDR == sscm_pkg::OFF_PERIPH_CFG) begin
                rdata_nxt = {24'h0, UART0_EXTCLK, CSI_EXTCLK, WDT2_SUB, WDT2_IOSC};
            end else if (PADDR == sscm_pkg::OFF_STATUS) begin
                rdata_nxt = {28'h0, state_r, adc_inv_r, dac_hold_r};
            end else if (PADDR == sscm_pkg::OFF_DAC_CTRL) begin
                rdata_nxt = {27'h0, settle_r, DAC_RESTORE};
            end else begin
                rdata_nxt = 32'h0;
                err_nxt   = 1'b1;
            end
        end else if (PSEL && PENABLE && PWRITE && !ready_r) begin
            if (PADDR != sscm_pkg::OFF_PROC_CLK_CTRL && PADDR != sscm_pkg::OFF_STAB_TIME &&
                PADDR != sscm_pkg::OFF_STOP_CTRL && PADDR != sscm_pkg::OFF_STATUS) begin
                err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            // reset reloads the default stabilisation setting
            div_r      <= sscm_pkg::DIV_RST;
            subsel_r   <= 1'b0;
            moscstp_r  <= 1'b0;
            stab_r     <= sscm_pkg::STAB_SEL_RST;
            adc_inv_r  <= 1'b0;
            dac_hold_r <= 1'b0;
            settle_r   <= 4'h0;
            cls_r      <= 1'b0;
            cls_cnt_r  <= 3'h0;
            rdata_r    <= 32'h0;
            err_r      <= 1'b0;
            ready_r    <= 1'b0;
            state_r    <= sscm_pkg::ST_RUN;
        end else if (CE) begin
            div_r      <= div_nxt;
            subsel_r   <= subsel_nxt;
            moscstp_r  <= moscstp_nxt;
            stab_r     <= stab_nxt;
            adc_inv_r  <= adc_inv_nxt;
            dac_hold_r <= dac_hold_nxt;
            settle_r   <= settle_nxt;
            cls_r      <= cls_nxt;
            cls_cnt_r  <= cls_cnt_nxt;
            rdata_r    <= rdata_nxt;
            err_r      <= err_nxt;
            ready_r    <= ready_nxt;
            state_r    <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // peripheral controls
    // ------------------------------------------------------------------
    logic halted;
    assign halted = (state_r != sscm_pkg::ST_RUN);

    always_comb begin
        PERIPH          = '0;
        PERIPH.wdt2_run = !halted || WDT2_IOSC || (SUB_USED && WDT2_SUB);
        PERIPH.csi_run  = halted ? CSI_EXTCLK : 5'h1f;
        PERIPH.i2c_run  = !halted;
        PERIPH.uart_run = halted ? {2'b00, UART0_EXTCLK} : 3'h7;
        PERIPH.adc_halt = halted;
        PERIPH.adc_invalid = adc_inv_r;
        PERIPH.dac_hiz  = halted && dac_hold_r;
        PERIPH.rto_hold = halted;
        PERIPH.port_hold = halted;
        PERIPH.cpu_hold = halted;
    end

    assign PRDATA      = rdata_r;
    assign PREADY      = ready_r;
    assign PSLVERR     = err_r && ready_r;
    // main oscillator off while stopped or when software stops it
    assign MAIN_OSC_EN = !(state_r == sscm_pkg::ST_STOP) && !moscstp_r;
    assign SYSCLK_SUB  = cls_r;
    assign SYS_DIV     = div_r;
    assign DAC_OE_N    = !(PERIPH.dac_hiz == 1'b0);
    assign DAC_RESTORE = (state_r == sscm_pkg::ST_RUN) && (settle_r == 4'h1);
    assign IN_STOP     = (state_r == sscm_pkg::ST_STOP);
endmodule

//--- tb/sscm_checker.sv
// sscm_chk: port-level assertions for the stop and subclock controller
// assumes bound to sscm_top, one clock domain, async active-low reset
`timescale 1ns/100ps
module sscm_chk (
    input wire logic                   CLK,          // clock
    input wire logic                   RST_N,        // reset
    input wire logic                   CE,           // enable
    input wire logic                   NMI_REQ,      // wake
    input wire logic                   INT_REQ,      // wake
    input wire logic                   SUB_USED,     // cfg
    input wire logic                   WDT2_IOSC,    // cfg
    input wire logic                   WDT2_SUB,     // cfg
    input wire logic [4:0]             CSI_EXTCLK,   // cfg
    input wire logic                   UART0_EXTCLK, // cfg
    input wire logic                   ADC_BUSY,     // adc busy
    input wire logic                   DAC_ACTIVE,   // dac busy
    input wire logic                   SUB_READY,    // ack
    input wire sscm_pkg::sscm_periph_t PERIPH,       // controls
    input wire logic                   MAIN_OSC_EN,  // osc
    input wire logic                   SYSCLK_SUB,   // sub clock
    input wire logic                   DAC_OE_N,     // dac pin
    input wire logic                   DAC_RESTORE,  // dac back
    input wire logic                   IN_STOP       // stop
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_wdt_in_stop: assert property (IN_STOP |-> PERIPH.wdt2_run == (WDT2_IOSC | (SUB_USED & WDT2_SUB)))
        else $error("watchdog run wrong in stop");
    a_csi_ext_only: assert property (IN_STOP |-> PERIPH.csi_run == CSI_EXTCLK)
        else $error("serial unit run wrong in stop");
    a_serial_halt: assert property (IN_STOP |-> !PERIPH.i2c_run && PERIPH.uart_run == {2'h0, UART0_EXTCLK})
        else $error("two-wire or async unit runs in stop");
    a_adc_halted: assert property ($rose(IN_STOP) && $past(ADC_BUSY) |-> PERIPH.adc_halt && PERIPH.adc_invalid)
        else $error("converter not halted or flagged");
    a_dac_float: assert property ($rose(IN_STOP) |-> DAC_OE_N == $past(DAC_ACTIVE))
        else $error("dac pin not floated at entry");
    a_dac_restore: assert property (DAC_RESTORE |-> !IN_STOP && !DAC_OE_N)
        else $error("dac restore while stopped");
    a_state_hold: assert property (IN_STOP |-> PERIPH.rto_hold && PERIPH.port_hold && PERIPH.cpu_hold)
        else $error("hold missing in stop");
    a_wake_exit: assert property (IN_STOP && CE && (NMI_REQ || INT_REQ) |=> !IN_STOP)
        else $error("wake did not leave stop");
    a_stop_stays: assert property (IN_STOP && CE && !NMI_REQ && !INT_REQ |=> IN_STOP)
        else $error("stop left without wake");
    a_osc_off: assert property (IN_STOP |-> !MAIN_OSC_EN)
        else $error("main oscillator runs in stop");
    a_sub_ack: assert property ($rose(SYSCLK_SUB) |-> $past(SUB_READY))
        else $error("clock status set without ack");

    cover property ($rose(IN_STOP) && DAC_OE_N);
    cover property ($fell(IN_STOP));
    cover property ($rose(SYSCLK_SUB));
    cover property (DAC_RESTORE);
endmodule

bind sscm_top sscm_chk u_chk (.CLK, .RST_N, .CE, .NMI_REQ, .INT_REQ, .SUB_USED, .WDT2_IOSC, .WDT2_SUB,
    .CSI_EXTCLK, .UART0_EXTCLK, .ADC_BUSY, .DAC_ACTIVE, .SUB_READY, .PERIPH, .MAIN_OSC_EN, .SYSCLK_SUB,
    .DAC_OE_N, .DAC_RESTORE, .IN_STOP);

//--- tb/tb_top.sv
// tb_top: directed bench for sscm_top
// assumes one wait state apb slave; stabilisation select 0 gives 4096 cycles
`timescale 1ns/100ps
module tb_top;
    logic        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, NMI_REQ, INT_REQ, SUB_USED;
    logic        WDT2_IOSC, WDT2_SUB, UART0_EXTCLK, ADC_BUSY, DAC_ACTIVE, SUB_READY;
    logic        MAIN_OSC_EN, SYSCLK_SUB, DAC_OE_N, DAC_RESTORE, IN_STOP, er, CE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [4:0]  CSI_EXTCLK;
    logic [2:0]  SYS_DIV;
    sscm_pkg::sscm_periph_t PERIPH;
    int          mismatches, n_checks, n_restore;

    sscm_top DUT (.CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .NMI_REQ, .INT_REQ, .SUB_USED, .WDT2_IOSC, .WDT2_SUB, .CSI_EXTCLK, .UART0_EXTCLK,
        .ADC_BUSY, .DAC_ACTIVE, .SUB_READY, .PERIPH, .MAIN_OSC_EN, .SYSCLK_SUB, .SYS_DIV, .DAC_OE_N,
        .DAC_RESTORE, .IN_STOP);

    initial CLK = 1'h0;
    always #4 CLK = ~CLK;
    always @(posedge CLK) if (DAC_RESTORE === 1'h1) n_restore++;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // request held until pready is seen at an edge; released after it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        PSEL <= 1'h1; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'h1);
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0; PENABLE <= 1'h0;
        @(posedge CLK);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk_bit(MAIN_OSC_EN, 1'h1);
        chk_bit(IN_STOP, 1'h0);
        // normal mode: every unit runs, nothing held
        chk_word(32'(PERIPH), 32'hffc0);
        apb(1'h0, sscm_pkg::OFF_PROC_CLK_CTRL, 32'h0, rd, er);
        chk_word(rd & 32'h5f, 32'h3);
        apb(1'h0, sscm_pkg::OFF_STAB_TIME, 32'h0, rd, er);
        chk_word(rd & 32'h7, 32'h4);
        $display("test reset done");
    endtask

    task automatic t_bad;
        apb(1'h0, 8'h20, 32'h0, rd, er);
        chk_bit(er, 1'h1);
        chk_word(rd, 32'h0);
        apb(1'h1, sscm_pkg::OFF_PERIPH_CFG, 32'hff, rd, er);
        chk_bit(er, 1'h1);
        $display("test refused access done");
    endtask

    // cfg is {uart0 ext, subclock used, wdt on subclock, wdt on internal osc}
    task automatic t_stop(input logic nmi, input logic dac, input logic [4:0] csi, input logic [3:0] cfg);
        sscm_pkg::sscm_periph_t exp;
        exp = '0;
        {UART0_EXTCLK, SUB_USED, WDT2_SUB, WDT2_IOSC} <= cfg;
        CSI_EXTCLK <= csi; ADC_BUSY <= 1'h1; DAC_ACTIVE <= dac;
        apb(1'h1, sscm_pkg::OFF_STATUS, 32'h2, rd, er);
        apb(1'h1, sscm_pkg::OFF_STAB_TIME, 32'h0, rd, er);
        apb(1'h1, sscm_pkg::OFF_STOP_CTRL, 32'h1, rd, er);
        chk_bit(IN_STOP, 1'h1);
        chk_bit(MAIN_OSC_EN, 1'h0);
        chk_bit(DAC_OE_N, dac);
        exp.wdt2_run = cfg[0] | (cfg[2] & cfg[1]);
        exp.csi_run = csi;
        exp.uart_run = {2'h0, cfg[3]};
        exp.adc_halt = 1'h1; exp.adc_invalid = 1'h1; exp.dac_hiz = dac;
        exp.rto_hold = 1'h1; exp.port_hold = 1'h1; exp.cpu_hold = 1'h1;
        chk_word(32'(PERIPH), 32'(exp));
        apb(1'h0, sscm_pkg::OFF_STATUS, 32'h0, rd, er);
        chk_word(rd & 32'he, 32'h6);
        chk_bit(IN_STOP, 1'h1);
        n_restore = 0;
        if (nmi) NMI_REQ <= 1'h1;
        else INT_REQ <= 1'h1;
        @(posedge CLK);
        NMI_REQ <= 1'h0; INT_REQ <= 1'h0;
        @(posedge CLK);
        chk_bit(IN_STOP, 1'h0);
        apb(1'h0, sscm_pkg::OFF_STATUS, 32'h0, rd, er);
        chk_word(rd & 32'hc, 32'h8);
        // still inside the 4096-cycle wait here
        repeat (3980) @(posedge CLK);
        apb(1'h0, sscm_pkg::OFF_STATUS, 32'h0, rd, er);
        chk_word(rd & 32'hc, 32'h8);
        repeat (150) @(posedge CLK);
        apb(1'h0, sscm_pkg::OFF_STATUS, 32'h0, rd, er);
        chk_word(rd & 32'hc, 32'h0);
        chk_bit(PERIPH.adc_halt, 1'h0);
        chk_bit(DAC_OE_N, 1'h0);
        chk_word(n_restore, {31'h0, dac});
        ADC_BUSY <= 1'h0;
        $display("test stop and wake done");
    endtask

    task automatic t_sub;
        apb(1'h1, sscm_pkg::OFF_PROC_CLK_CTRL, 32'hb, rd, er);
        // enable low must freeze the switch even with the ack present
        CE <= 1'h0; SUB_READY <= 1'h1;
        repeat (10) @(posedge CLK);
        chk_bit(SYSCLK_SUB, 1'h0);
        CE <= 1'h1; SUB_READY <= 1'h0;
        repeat (6) @(posedge CLK);
        chk_bit(SYSCLK_SUB, 1'h0);
        SUB_READY <= 1'h1;
        repeat (3) @(posedge CLK);
        chk_bit(SYSCLK_SUB, 1'h1);
        chk_word({29'h0, SYS_DIV}, 32'h3);
        apb(1'h0, sscm_pkg::OFF_PROC_CLK_CTRL, 32'h0, rd, er);
        chk_word(rd & 32'h1f, 32'h1b);
        apb(1'h1, sscm_pkg::OFF_PROC_CLK_CTRL, 32'h4b, rd, er);
        chk_bit(MAIN_OSC_EN, 1'h0);
        $display("test subclock done");
    endtask

    task automatic t_rst_stop;
        SUB_READY <= 1'h0;
        apb(1'h1, sscm_pkg::OFF_STOP_CTRL, 32'h1, rd, er);
        chk_bit(IN_STOP, 1'h1);
        RST_N <= 1'h0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'h1;
        @(posedge CLK);
        chk_bit(IN_STOP, 1'h0);
        chk_bit(MAIN_OSC_EN, 1'h1);
        chk_bit(SYSCLK_SUB, 1'h0);
        apb(1'h0, sscm_pkg::OFF_STAB_TIME, 32'h0, rd, er);
        chk_word(rd & 32'h7, 32'h4);
        $display("test reset in stop done");
    endtask

    initial begin
        mismatches = 0; n_checks = 0; n_restore = 0;
        RST_N = 1'h0; PSEL = 1'h0; PENABLE = 1'h0; PWRITE = 1'h0; PADDR = 8'h0; PWDATA = 32'h0; CE = 1'h1;
        NMI_REQ = 1'h0; INT_REQ = 1'h0; SUB_USED = 1'h0; WDT2_IOSC = 1'h0; WDT2_SUB = 1'h0;
        CSI_EXTCLK = 5'h0; UART0_EXTCLK = 1'h0; ADC_BUSY = 1'h0; DAC_ACTIVE = 1'h0; SUB_READY = 1'h0;
        repeat (16) @(posedge CLK);
        RST_N <= 1'h1;
        @(posedge CLK);
        t_reset;
        t_bad;
        t_stop(1'h1, 1'h1, 5'h15, 4'ha);
        t_stop(1'h0, 1'h0, 5'h0a, 4'h6);
        t_sub;
        t_rst_stop;
        close_out;
    end

    // two stabilisation waits dominate; 20000 cycles is ample margin
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        close_out;
    end
endmodule
